// ===== logic/wpc_power_ctrl.sv
// Notes on behaviour
// - Falling edge on either modem line is a wake event.
// - Same-type events closer than 2.5 slow-clock periods may be lost.
// - Controller registers ignore system reset; cleared only at first power.
// - Delay select bit picks 5 or 21 second switch-off delay.
// - Mode bit makes alert a one-cycle pulse or a level held until cleared.
// - Command bits write-only, read zero; clear alert, supply, fail-safe timer.
// - Mask bit off restores old state; on with fail flag only switch-on wakes.
// - Fail flag set on move to battery; cleared by writing one.
// - Four enables let their events raise the supply; mask still overrides.
// - Call source select picks one of two ring pins.
// - Train mode needs edges in three slots after an empty slot.
// - Switch-off drops supply at once, or after delay when delay enabled.
// - Reading status clears bits 5..0 and returns their old values.
// - Time match flag sets regardless of enable; reset value has it set.
// - Call and modem flags set by their events regardless of enables.
// - Fail-safe flag on terminal count; switch-off flag on every switch-off.
// - Status bit 7 shows live level of selected ring pin.
// - Lock bits stay set until the hard clear pin.
// - Lock bit 3 blocks the upper data port: writes ignored, reads FFh.
// - Lock bits 4 and 5 block reads and writes of upper bytes 00h-1Fh.
// - Lock bit 6 blocks writes to general bank RAM and upper RAM.
// - Lock bit 7 blocks locations 38h-3Fh of every bank.
module wpc_power_ctrl
  import wpc_pkg::*;
#(
  parameter int unsigned OFF_SHORT_CYC = OFF_SHORT_CYC_DEF,
  parameter int unsigned OFF_LONG_CYC = OFF_LONG_CYC_DEF,
  parameter int unsigned RESTORE_CYC = RESTORE_CYC_DEF,
  parameter int unsigned SLOT_CYC = SLOT_CYC_DEF,
  parameter int unsigned GAP_CYC = GAP_CYC_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hardClear_n,
  input wire logic [1:0] regBank,
  input wire logic [6:0] regIndex,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [6:0] upperAddr,
  output logic [7:0] regRdata,
  output wpc_gate_s ramGate,
  input wire wpc_evt_s events,
  input wire logic modemLineOne_n,
  input wire logic modemLineTwo_n,
  input wire logic callPinA_n,
  input wire logic callPinB_n,
  input wire logic onBattery,
  output logic supplyOnOut,
  output logic powerOffAlert_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  logic apcBank;
  logic wrOne;
  logic wrTwo;
  logic wrLock;
  logic readFlags;
  logic [7:0] wakeTwo_ff;
  logic delaySel_ff;
  logic alertLevel_ff;
  logic maskWake_ff;
  logic pwrFail_ff;
  logic [5:0] flags_ff;
  logic [7:0] lock_ff;
  logic [7:0] regRdata_ff;
  logic pinLevel;
  assign apcBank = (regBank == BANK_APC);
  assign wrOne = regWrite && apcBank && (regIndex == IDX_POWER_ONE);
  assign wrTwo = regWrite && apcBank && (regIndex == IDX_WAKE_TWO);
  assign wrLock = regWrite && apcBank && (regIndex == IDX_LOCK);
  assign readFlags = regRead && apcBank && (regIndex == IDX_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Power state tracking across supply failure.
  wpc_pwr_e pwr_ff;
  logic [31:0] restCnt_ff;
  logic saved_ff;
  logic tmPend_ff;
  logic wakeOpen;
  logic restoreNow;
  logic failEntry;
  assign wakeOpen = (pwr_ff == PW_NORMAL);
  assign failEntry = wakeOpen && onBattery;
  assign restoreNow = (pwr_ff == PW_RETURN) && !onBattery &&
                      (restCnt_ff == 32'(RESTORE_CYC - 1));
  // This state lives on the first-power reset only.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwr_ff <= PW_NORMAL;
      restCnt_ff <= '0;
      saved_ff <= 1'b0;
      tmPend_ff <= 1'b0;
    end else begin
      unique case (pwr_ff)
        PW_NORMAL: begin
          tmPend_ff <= 1'b0;
          if (onBattery) begin
            pwr_ff <= PW_FAIL;
            saved_ff <= supplyOnOut;
          end
        end
        PW_FAIL: begin
          if (events.timeMatch) begin
            tmPend_ff <= 1'b1;
          end
          if (!onBattery) begin
            pwr_ff <= PW_RETURN;
            restCnt_ff <= '0;
          end
        end
        PW_RETURN: begin
          if (events.timeMatch) begin
            tmPend_ff <= 1'b1;
          end
          if (onBattery) begin
            pwr_ff <= PW_FAIL;
          end else if (restoreNow) begin
            pwr_ff <= PW_NORMAL;
          end else begin
            restCnt_ff <= restCnt_ff + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection with a hold-off window per source.
  logic [2:0] lineRaw;
  logic [2:0] edgeHit;
  logic [2:0] rawFall;
  logic linePrev_ff [3];
  logic [15:0] gapCnt_ff [3];
  assign pinLevel = wakeTwo_ff[B_CALL_SEL] ? callPinB_n : callPinA_n;
  assign lineRaw = {modemLineTwo_n, modemLineOne_n, pinLevel};
  for (genvar gi = 0; gi < 3; gi++) begin : g_edge
    assign rawFall[gi] = linePrev_ff[gi] && !lineRaw[gi];
    // A second fall inside the window is dropped.
    assign edgeHit[gi] = rawFall[gi] && (gapCnt_ff[gi] == 16'h0000) && wakeOpen;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        linePrev_ff[gi] <= 1'b1;
        gapCnt_ff[gi] <= 16'h0000;
      end else begin
        linePrev_ff[gi] <= lineRaw[gi];
        if (edgeHit[gi]) begin
          gapCnt_ff[gi] <= 16'(GAP_CYC);
        end else if (gapCnt_ff[gi] != 16'h0000) begin
          gapCnt_ff[gi] <= gapCnt_ff[gi] - 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ring train detection over fixed slots.
  logic [31:0] slotCnt_ff;
  logic slotEdge_ff;
  logic [2:0] hist_ff;
  logic slotEnd;
  logic slotNow;
  logic trainHit;
  logic callEvt;
  assign slotEnd = (slotCnt_ff == 32'(SLOT_CYC - 1));
  assign slotNow = slotEdge_ff || rawFall[0];
  assign trainHit = slotEnd && wakeOpen && ({hist_ff, slotNow} == TRAIN_PATTERN);
  assign callEvt = wakeTwo_ff[B_TRAIN] ? trainHit : edgeHit[0];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      slotCnt_ff <= '0;
      slotEdge_ff <= 1'b0;
      hist_ff <= 3'h0;
    end else if (slotEnd) begin
      slotCnt_ff <= '0;
      slotEdge_ff <= 1'b0;
      hist_ff <= {hist_ff[1:0], slotNow};
    end else begin
      slotCnt_ff <= slotCnt_ff + 32'h0000_0001;
      slotEdge_ff <= slotNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe timer for the delayed switch-off.
  logic offEvt;
  logic onEvt;
  logic fsRun_ff;
  logic [31:0] fsCnt_ff;
  logic [31:0] fsLimit;
  logic fsTerm;
  logic fsStart;
  assign offEvt = events.switchOff && wakeOpen;
  assign onEvt = events.switchOn && wakeOpen;
  assign fsLimit = delaySel_ff ? 32'(OFF_LONG_CYC - 1) : 32'(OFF_SHORT_CYC - 1);
  assign fsTerm = fsRun_ff && (fsCnt_ff == fsLimit);
  // Switch-off events while counting do not restart the count.
  assign fsStart = offEvt && wakeTwo_ff[B_OFF_DLY_EN] && !fsRun_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fsRun_ff <= 1'b0;
      fsCnt_ff <= '0;
    end else if ((wrOne && regWdata[B_TIMER_RST]) || fsTerm || onBattery) begin
      fsRun_ff <= 1'b0;
      fsCnt_ff <= '0;
    end else if (fsStart) begin
      fsRun_ff <= 1'b1;
      fsCnt_ff <= '0;
    end else if (fsRun_ff) begin
      fsCnt_ff <= fsCnt_ff + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply control.
  logic supplyOn_ff;
  logic nxt_supplyOn;
  logic wakeHit;
  logic offNow;
  assign offNow = (offEvt && !wakeTwo_ff[B_OFF_DLY_EN]) || fsTerm ||
                  (wrOne && regWdata[B_SOFT_OFF]);
  assign wakeHit = ((wakeTwo_ff[B_TM_EN] && events.timeMatch) ||
                    (wakeTwo_ff[B_CALL_EN] && callEvt) ||
                    (wakeTwo_ff[B_L1_EN] && edgeHit[1]) ||
                    (wakeTwo_ff[B_L2_EN] && edgeHit[2])) &&
                   !(maskWake_ff && pwrFail_ff);
  always_comb begin
    nxt_supplyOn = supplyOn_ff;
    if (!wakeOpen || failEntry) begin
      nxt_supplyOn = 1'b0;
      if (restoreNow) begin
        nxt_supplyOn = !maskWake_ff && (saved_ff || tmPend_ff);
      end
    end else begin
      if (wakeHit || onEvt) begin
        nxt_supplyOn = 1'b1;
      end
      if (offNow) begin
        nxt_supplyOn = 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      supplyOn_ff <= 1'b0;
    end else begin
      supplyOn_ff <= nxt_supplyOn;
    end
  end
  assign supplyOnOut = supplyOn_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Power-off alert.
  logic alert_ff;
  // A new switch-off wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alert_ff <= 1'b0;
    end else if (offEvt) begin
      alert_ff <= 1'b1;
    end else if (!alertLevel_ff || (wrOne && regWdata[B_ALERT_CLR])) begin
      alert_ff <= 1'b0;
    end
  end
  assign powerOffAlert_n = !alert_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      delaySel_ff <= 1'b0;
      alertLevel_ff <= 1'b0;
      maskWake_ff <= 1'b0;
    end else if (wrOne) begin
      delaySel_ff <= regWdata[B_DELAY_SEL];
      alertLevel_ff <= regWdata[B_ALERT_LEVEL];
      maskWake_ff <= regWdata[B_MASK_WAKE];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwrFail_ff <= 1'b0;
    end else if (failEntry) begin
      pwrFail_ff <= 1'b1;
    end else if (wrOne && regWdata[B_PWR_FAIL]) begin
      pwrFail_ff <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wakeTwo_ff <= WAKE_TWO_RST;
    end else if (wrTwo) begin
      wakeTwo_ff <= regWdata & WAKE_TWO_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags, cleared on read with a same-cycle event kept.
  logic [5:0] evtVec;
  assign evtVec = {offEvt, fsTerm, edgeHit[2], edgeHit[1], callEvt,
                   events.timeMatch};
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= FLAGS_RST;
    end else begin
      flags_ff <= (readFlags ? 6'h00 : flags_ff) | evtVec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM lock bits and access gating.
  logic upperPort;
  logic lowGuard;
  logic lockedZone;
  logic gpRam;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_ff <= LOCK_RST;
    end else if (!hardClear_n) begin
      lock_ff <= LOCK_RST;
    end else if (wrLock) begin
      lock_ff <= lock_ff | (regWdata & LOCK_MASK);
    end
  end
  assign upperPort = (regBank == BANK_UPPER) && (regIndex == IDX_UPPER_DATA);
  assign lowGuard = (upperAddr <= UPPER_GUARD_TOP);
  assign lockedZone = (regIndex[6:3] == LOCKED_ZONE_HI);
  assign gpRam = (regBank == BANK_GP) && regIndex[6];
  assign ramGate.writeOk =
    !((upperPort && (lock_ff[L_UPPER] || (lock_ff[L_UP_WR] && lowGuard))) ||
      ((upperPort || gpRam) && lock_ff[L_MASK_WR]) ||
      (lockedZone && lock_ff[L_ZONE]));
  assign ramGate.readForced =
    (upperPort && (lock_ff[L_UPPER] || (lock_ff[L_UP_RD] && lowGuard))) ||
    (lockedZone && lock_ff[L_ZONE]);

  ////////////////////////////////////////////////////////////////////////////
  // Read data; command bits and reserved bits read zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regRdata_ff <= 8'h00;
    end else if (regRead) begin
      regRdata_ff <= 8'h00;
      if (apcBank) begin
        unique case (regIndex)
          IDX_POWER_ONE: regRdata_ff <= {pwrFail_ff, 2'b00, maskWake_ff, 1'b0,
                                         alertLevel_ff, delaySel_ff, 1'b0};
          IDX_WAKE_TWO: regRdata_ff <= wakeTwo_ff;
          IDX_FLAGS: regRdata_ff <= {pinLevel, 1'b0, flags_ff};
          IDX_LOCK: regRdata_ff <= lock_ff;
          default: regRdata_ff <= 8'h00;
        endcase
      end
    end
  end
  assign regRdata = regRdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  alert_raise_a: assert property (offEvt |=> !powerOffAlert_n)
    else $error("alert not raised after switch-off");
  alert_pulse_a: assert property (!powerOffAlert_n && !alertLevel_ff && !offEvt
    |=> powerOffAlert_n)
    else $error("edge alert longer than one cycle");
  soft_off_a: assert property (wakeOpen && wrOne && regWdata[B_SOFT_OFF]
    |=> !supplyOnOut)
    else $error("software off did not drop supply");
  read_clear_a: assert property (readFlags && (evtVec == 6'h00)
    |=> (flags_ff == 6'h00) && (regRdata[5:0] == $past(flags_ff)))
    else $error("status read did not clear or return old flags");
  fail_flag_a: assert property (failEntry |=> pwrFail_ff && !supplyOnOut)
    else $error("power failure not recorded");
  lock_sticky_a: assert property (lock_ff[L_ZONE] && hardClear_n |=> lock_ff[L_ZONE])
    else $error("lock bit dropped without hard clear");
  upper_block_a: assert property (lock_ff[L_UPPER] && upperPort
    |-> ramGate.readForced && !ramGate.writeOk)
    else $error("upper port not blocked");
  off_now_a: assert property (offEvt && !wakeTwo_ff[B_OFF_DLY_EN] |=> !supplyOnOut)
    else $error("immediate switch-off failed");
  gap_a: assert property (edgeHit[1] |=> !edgeHit[1] ##1 !edgeHit[1])
    else $error("events inside the hold-off window");
  mask_a: assert property (wakeOpen && maskWake_ff && pwrFail_ff && !supplyOnOut &&
    !events.switchOn |=> !supplyOnOut)
    else $error("supply raised while masked");
  fs_term_a: assert property (fsTerm |=> flags_ff[F_FAILSAFE] && !supplyOnOut)
    else $error("fail-safe expiry not handled");
  line_wake_a: assert property (wakeOpen && wakeTwo_ff[B_L1_EN] && edgeHit[1] &&
    !maskWake_ff && !offNow && !onBattery |=> supplyOnOut)
    else $error("modem line wake failed");
  fs_done_c: cover property (fsStart ##[1:1000] fsTerm);
  train_c: cover property (trainHit && wakeTwo_ff[B_TRAIN]);
  restore_c: cover property (restoreNow && saved_ff);
  lock_c: cover property (wrLock ##1 ramGate.readForced);
endmodule

// ===== shared/wpc_pkg.sv
package wpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register index space and bank selection.
  localparam logic [1:0] BANK_GP = 2'h0;
  localparam logic [1:0] BANK_UPPER = 2'h1;
  localparam logic [1:0] BANK_APC = 2'h2;
  localparam logic [6:0] IDX_POWER_ONE = 7'h40;
  localparam logic [6:0] IDX_WAKE_TWO = 7'h41;
  localparam logic [6:0] IDX_FLAGS = 7'h42;
  localparam logic [6:0] IDX_LOCK = 7'h47;
  localparam logic [6:0] IDX_UPPER_DATA = 7'h53;
  localparam logic [3:0] LOCKED_ZONE_HI = 4'h7;
  localparam logic [6:0] UPPER_GUARD_TOP = 7'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int B_DELAY_SEL = 1;
  localparam int B_ALERT_LEVEL = 2;
  localparam int B_ALERT_CLR = 3;
  localparam int B_MASK_WAKE = 4;
  localparam int B_SOFT_OFF = 5;
  localparam int B_TIMER_RST = 6;
  localparam int B_PWR_FAIL = 7;
  localparam int B_TM_EN = 0;
  localparam int B_CALL_SEL = 1;
  localparam int B_TRAIN = 2;
  localparam int B_CALL_EN = 3;
  localparam int B_L1_EN = 4;
  localparam int B_L2_EN = 5;
  localparam int B_OFF_DLY_EN = 6;
  localparam int F_FAILSAFE = 4;
  localparam int L_UPPER = 3;
  localparam int L_UP_RD = 4;
  localparam int L_UP_WR = 5;
  localparam int L_MASK_WR = 6;
  localparam int L_ZONE = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constants.
  localparam logic [7:0] WAKE_TWO_RST = 8'h00;
  localparam logic [7:0] WAKE_TWO_MASK = 8'h7f;
  localparam logic [5:0] FLAGS_RST = 6'h01;
  localparam logic [7:0] LOCK_RST = 8'h00;
  localparam logic [7:0] LOCK_MASK = 8'hf8;
  localparam logic [3:0] TRAIN_PATTERN = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Times and derived cycle counts at the 100 MHz clock.
  localparam longint unsigned CLK_PERIOD_NS = 10;
  localparam longint unsigned OFF_SHORT_MS = 5;
  localparam longint unsigned OFF_LONG_MS = 21;
  localparam longint unsigned RESTORE_MS = 1000;
  localparam longint unsigned SLOT_NS = 62_500_000;
  localparam longint unsigned EVT_GAP_NS = 78_125;
  localparam int unsigned OFF_SHORT_CYC_DEF =
    32'(OFF_SHORT_MS * 1000 * 1_000_000 / CLK_PERIOD_NS);
  localparam int unsigned OFF_LONG_CYC_DEF =
    32'(OFF_LONG_MS * 1000 * 1_000_000 / CLK_PERIOD_NS);
  localparam int unsigned RESTORE_CYC_DEF = 32'(RESTORE_MS * 1_000_000 / CLK_PERIOD_NS);
  localparam int unsigned SLOT_CYC_DEF = 32'(SLOT_NS / CLK_PERIOD_NS);
  localparam int unsigned GAP_CYC_DEF = 32'((EVT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Carriers and states.
  typedef struct packed {
    logic switchOn;
    logic switchOff;
    logic timeMatch;
  } wpc_evt_s;

  typedef struct packed {
    logic writeOk;
    logic readForced;
  } wpc_gate_s;

  typedef enum logic [1:0] {PW_NORMAL, PW_FAIL, PW_RETURN} wpc_pwr_e;

endpackage

// ===== testbench/wake_power_control_regs_bench.sv
module wake_power_control_regs_bench
  import wpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////
  localparam wpc_evt_s ON = 3'b100;
  localparam wpc_evt_s OFF = 3'b010;
  localparam wpc_evt_s TM = 3'b001;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic hardClear_n = 1'b1;
  logic [1:0] regBank = 2'h0;
  logic [6:0] regIndex = 7'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [6:0] upperAddr = 7'h00;
  logic [7:0] regRdata;
  wpc_gate_s ramGate;
  wpc_evt_s events = '0;
  logic onBattery = 1'b0;
  logic supplyOnOut;
  logic powerOffAlert_n;
  logic [3:0] fire = 4'h0;
  logic [3:0] hold = 4'h0;
  logic [3:0] line_n;
  logic [31:0] seed = 32'hd723_1866;
  int miscompares = 0;
  int nCompared = 0;

  always #5 clock = ~clock;

  wpc_power_ctrl #(.OFF_SHORT_CYC(50), .OFF_LONG_CYC(200), .RESTORE_CYC(20), .SLOT_CYC(10),
    .GAP_CYC(4)) dut_u (.clock(clock), .reset_n(reset_n), .hardClear_n(hardClear_n),
    .regBank(regBank), .regIndex(regIndex), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .upperAddr(upperAddr), .regRdata(regRdata), .ramGate(ramGate),
    .events(events), .modemLineOne_n(line_n[0]), .modemLineTwo_n(line_n[1]),
    .callPinA_n(line_n[2]), .callPinB_n(line_n[3]), .onBattery(onBattery),
    .supplyOnOut(supplyOnOut), .powerOffAlert_n(powerOffAlert_n));

  wpc_wake_src src_u (.clock(clock), .reset_n(reset_n), .fire(fire), .hold(hold),
    .line_n(line_n));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d, input logic [1:0] b = BANK_APC);
    step(1);
    regBank = b;
    regIndex = i;
    regWdata = d;
    regWrite = 1'b1;
    step(1);
    regWrite = 1'b0;
  endtask

  task automatic chkr(input logic [6:0] i, input logic [7:0] m, input logic [7:0] e);
    step(1);
    regBank = BANK_APC;
    regIndex = i;
    regRead = 1'b1;
    step(1);
    regRead = 1'b0;
    check(regRdata & m, e);
  endtask

  task automatic sup(input logic e);
    check({7'h0, supplyOnOut}, {7'h0, e});
  endtask

  task automatic alr(input logic e);
    check({7'h0, powerOffAlert_n}, {7'h0, e});
  endtask

  task automatic evt(input wpc_evt_s e);
    step(1);
    events = e;
    step(1);
    events = '0;
  endtask

  task automatic pulse_line(input int k);
    step(1);
    fire[k] = 1'b1;
    step(1);
    fire[k] = 1'b0;
    step(4);
  endtask

  task automatic gate(input logic [7:0] lk, input logic [1:0] b, input logic [6:0] i,
    input logic [6:0] ua, input logic wok, input logic rf);
    step(1);
    hardClear_n = 1'b0;
    step(1);
    hardClear_n = 1'b1;
    wr(IDX_LOCK, lk);
    regBank = b;
    regIndex = i;
    upperAddr = ua;
    step(1);
    check({7'h0, ramGate.writeOk}, {7'h0, wok});
    check({7'h0, ramGate.readForced}, {7'h0, rf});
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    repeat (10) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chkr(IDX_POWER_ONE, 8'hff, 8'h00);
    chkr(IDX_WAKE_TWO, 8'hff, 8'h00);
    chkr(IDX_FLAGS, 8'hff, 8'h81);
    chkr(IDX_FLAGS, 8'hff, 8'h80);
    chkr(IDX_LOCK, 8'hff, 8'h00);
    for (int n = 0; n < 8; n++) begin
      r = xs();
      wr(IDX_POWER_ONE, r);
      chkr(IDX_POWER_ONE, 8'hff, r & 8'h16);
      r = xs();
      wr(IDX_WAKE_TWO, r);
      chkr(IDX_WAKE_TWO, 8'hff, r & 8'h7f);
      wr(7'h49, xs());
      chkr(7'h49, 8'hff, 8'h00);
    end
    wr(IDX_POWER_ONE, 8'h00);
    $display("test registers finished");
    wr(IDX_WAKE_TWO, 8'h10);
    pulse_line(1);
    sup(1'b0);
    pulse_line(0);
    sup(1'b1);
    wr(IDX_POWER_ONE, 8'h20);
    sup(1'b0);
    wr(IDX_WAKE_TWO, 8'h20);
    pulse_line(1);
    sup(1'b1);
    chkr(IDX_FLAGS, 8'hff, 8'h8c);
    $display("test modem finished");
    wr(IDX_WAKE_TWO, 8'h00);
    evt(OFF);
    alr(1'b0);
    sup(1'b0);
    step(1);
    alr(1'b1);
    chkr(IDX_FLAGS, 8'h3f, 8'h20);
    wr(IDX_WAKE_TWO, 8'h40);
    wr(IDX_POWER_ONE, 8'h04);
    evt(ON);
    evt(OFF);
    step(40);
    sup(1'b1);
    alr(1'b0);
    step(20);
    sup(1'b0);
    chkr(IDX_FLAGS, 8'h3f, 8'h30);
    wr(IDX_POWER_ONE, 8'h0c);
    step(1);
    alr(1'b1);
    chkr(IDX_POWER_ONE, 8'hff, 8'h04);
    wr(IDX_POWER_ONE, 8'h00);
    evt(ON);
    evt(OFF);
    step(10);
    wr(IDX_POWER_ONE, 8'h40);
    step(60);
    sup(1'b1);
    wr(IDX_POWER_ONE, 8'h02);
    evt(OFF);
    step(190);
    sup(1'b1);
    step(20);
    sup(1'b0);
    evt(ON);
    wr(IDX_POWER_ONE, 8'h20);
    step(1);
    sup(1'b0);
    chkr(IDX_POWER_ONE, 8'hff, 8'h00);
    $display("test switch off finished");
    evt(ON);
    onBattery = 1'b1;
    step(3);
    sup(1'b0);
    chkr(IDX_POWER_ONE, 8'hff, 8'h80);
    onBattery = 1'b0;
    step(10);
    sup(1'b0);
    step(20);
    sup(1'b1);
    wr(IDX_POWER_ONE, 8'h00);
    chkr(IDX_POWER_ONE, 8'hff, 8'h80);
    wr(IDX_POWER_ONE, 8'h80);
    chkr(IDX_POWER_ONE, 8'hff, 8'h00);
    wr(IDX_POWER_ONE, 8'h10);
    onBattery = 1'b1;
    step(3);
    onBattery = 1'b0;
    step(30);
    sup(1'b0);
    wr(IDX_WAKE_TWO, 8'h10);
    pulse_line(0);
    sup(1'b0);
    evt(ON);
    sup(1'b1);
    wr(IDX_POWER_ONE, 8'h80);
    chkr(IDX_FLAGS, 8'h04, 8'h04);
    $display("test power fail finished");
    wr(IDX_WAKE_TWO, 8'h08);
    wr(IDX_POWER_ONE, 8'h20);
    pulse_line(3);
    sup(1'b0);
    pulse_line(2);
    sup(1'b1);
    chkr(IDX_FLAGS, 8'h02, 8'h02);
    wr(IDX_WAKE_TWO, 8'h0a);
    hold[3] = 1'b1;
    chkr(IDX_FLAGS, 8'h80, 8'h00);
    wr(IDX_WAKE_TWO, 8'h08);
    chkr(IDX_FLAGS, 8'h80, 8'h80);
    hold[3] = 1'b0;
    wr(IDX_POWER_ONE, 8'h20);
    wr(IDX_WAKE_TWO, 8'h0c);
    step(30);
    chkr(IDX_FLAGS, 8'h80, 8'h80);
    pulse_line(2);
    step(40);
    chkr(IDX_FLAGS, 8'h02, 8'h00);
    sup(1'b0);
    for (int k = 0; k < 6; k++) begin
      pulse_line(2);
    end
    step(20);
    chkr(IDX_FLAGS, 8'h02, 8'h02);
    sup(1'b1);
    $display("test call finished");
    wr(IDX_POWER_ONE, 8'h20);
    evt(TM);
    sup(1'b0);
    chkr(IDX_FLAGS, 8'h01, 8'h01);
    wr(IDX_WAKE_TWO, 8'h01);
    evt(TM);
    sup(1'b1);
    chkr(IDX_FLAGS, 8'h01, 8'h01);
    wr(IDX_POWER_ONE, 8'h20);
    onBattery = 1'b1;
    step(3);
    sup(1'b0);
    evt(TM);
    onBattery = 1'b0;
    step(30);
    sup(1'b1);
    chkr(IDX_FLAGS, 8'h01, 8'h01);
    wr(IDX_POWER_ONE, 8'h80);
    $display("test time match finished");
    wr(IDX_LOCK, 8'hff);
    chkr(IDX_LOCK, 8'hff, 8'hf8);
    wr(IDX_LOCK, 8'h00);
    chkr(IDX_LOCK, 8'hff, 8'hf8);
    gate(8'h00, BANK_GP, 7'h38, 7'h00, 1'b1, 1'b0);
    gate(8'h10, BANK_UPPER, IDX_UPPER_DATA, 7'h10, 1'b1, 1'b1);
    gate(8'h10, BANK_UPPER, IDX_UPPER_DATA, 7'h20, 1'b1, 1'b0);
    gate(8'h20, BANK_UPPER, IDX_UPPER_DATA, 7'h1f, 1'b0, 1'b0);
    gate(8'h20, BANK_UPPER, IDX_UPPER_DATA, 7'h20, 1'b1, 1'b0);
    gate(8'h08, BANK_UPPER, IDX_UPPER_DATA, 7'h20, 1'b0, 1'b1);
    gate(8'h40, BANK_GP, 7'h40, 7'h00, 1'b0, 1'b0);
    gate(8'h40, BANK_UPPER, IDX_UPPER_DATA, 7'h40, 1'b0, 1'b0);
    gate(8'h80, BANK_APC, 7'h39, 7'h00, 1'b0, 1'b1);
    gate(8'h80, BANK_GP, 7'h3f, 7'h00, 1'b0, 1'b1);
    $display("test lock finished");
    end_of_test();
  end
endmodule

// ===== testbench/wpc_wake_src.sv
module wpc_wake_src
  import wpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] fire,
  input wire logic [3:0] hold,
  output logic [3:0] line_n
);
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////
  // Each request pulls its line low for two cycles; pull-ups keep idle lines high.
  logic [1:0] lowCnt_ff [4];

  always_ff @(posedge clock or negedge reset_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!reset_n) begin
        lowCnt_ff[i] <= 2'h0;
      end else if (fire[i]) begin
        lowCnt_ff[i] <= 2'h2;
      end else if (lowCnt_ff[i] != 2'h0) begin
        lowCnt_ff[i] <= lowCnt_ff[i] - 2'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line_n[i] = !(hold[i] || lowCnt_ff[i] != 2'h0);
    end
  end
endmodule
